/* dv/dtc_src_model.sv */
// Purpose: far-side event source toggling both count pins
// Assumes: pins change at the falling clock edge
// Notes: each level lasts 2 to 4 clocks so every edge is sampled
`timescale 1ns/1ps
module dtc_src_model (
  // clock and enables
  input wire logic mclk,
  input wire logic [1:0] en,
  // pins and falling-edge tallies
  output logic [1:0] pin,
  output logic [1:0][15:0] falls
);
  int hold [2];
  initial begin
    pin = 2'b11;
    falls = '0;
    hold = '{1, 1};
  end
  always @(negedge mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (en[i] && hold[i] <= 1) begin
        pin[i] <= ~pin[i];
        if (pin[i]) falls[i] <= falls[i] + 16'h0001;
        hold[i] <= 2 + $urandom_range(2);
      end else if (hold[i] > 1) begin
        hold[i] <= hold[i] - 1;
      end
    end
  end
endmodule : dtc_src_model

/* dv/dual_timer_count_source_tb_top.sv */
// Purpose: self-checking bench for the dual count source
// Assumes: one clock, inputs driven at the falling edge
// Notes: each window is 12n clocks so internal ticks give exactly n
`timescale 1ns/1ps
module dual_timer_count_source_tb_top;
  logic mclk = 0;
  logic rstn = 0;
  dtc_pkg::dtc_ctrl_s ctrl0 = '0;
  dtc_pkg::dtc_ctrl_s ctrl1 = '0;
  logic [1:0] gate = '0;
  logic [1:0] en = '0;
  logic [1:0] pin;
  logic [1:0][15:0] falls;
  logic [15:0] count0, count1, b0, b1, f0, f1;
  logic [1:0] wrap;
  logic [3:0] sc0, sc1;
  logic [3:0] sp0 = '0;
  logic [3:0] sp1 = '0;
  logic [15:0] fp0 = '0;
  logic [15:0] fp1 = '0;
  logic [1:0] swrap;
  logic [3:0] v;
  int err_count = 0;
  int samples_checked = 0;
  int n;
  always #4 mclk = ~mclk;
  dtc_top u_dut (.mclk(mclk), .rstn(rstn), .ctrl0(ctrl0), .ctrl1(ctrl1), .first_count_input(pin[0]),
    .second_count_input(pin[1]), .count_gate_input(gate), .count0(count0), .count1(count1), .wrap(wrap));
  // narrow copy on the same inputs so that rollover is reached within the run
  dtc_top #(.CNT_W(4)) u_small (.mclk(mclk), .rstn(rstn), .ctrl0(ctrl0), .ctrl1(ctrl1),
    .first_count_input(pin[0]), .second_count_input(pin[1]), .count_gate_input(gate), .count0(sc0),
    .count1(sc1), .wrap(swrap));
  dtc_src_model u_src (.mclk(mclk), .en(en), .pin(pin), .falls(falls));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // rollover pulse stands exactly when a count stepped from all ones to zero
  always @(negedge mclk) begin
    chk("wrap0 narrow", 16'(swrap[0]), 16'(sp0 == 4'hf && sc0 == 4'h0));
    chk("wrap1 narrow", 16'(swrap[1]), 16'(sp1 == 4'hf && sc1 == 4'h0));
    chk("wrap0 full", 16'(wrap[0]), 16'(fp0 == 16'hffff && count0 == 16'h0000));
    chk("wrap1 full", 16'(wrap[1]), 16'(fp1 == 16'hffff && count1 == 16'h0000));
    sp0 <= sc0;
    sp1 <= sc1;
    fp0 <= count0;
    fp1 <= count1;
  end
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask : cyc
  // expected advance over a window of 12n clocks
  function automatic logic [15:0] step(input dtc_pkg::dtc_ctrl_s c, input logic g, input int k,
    input logic [15:0] f);
    if (!c.run || (c.gate_opt && !g)) return 16'h0000;
    return c.src_sel ? f : 16'(k);
  endfunction : step
  initial begin
    void'($urandom(32'h25d5));
    cyc(2);
    rstn = 1;
    chk("count0 reset", count0, 16'h0000);
    chk("count width", 16'($bits(u_dut.count1)), 16'h0010);
    for (int t = 0; t < 24; t++) begin
      v = (t < 16) ? 4'(t) : 4'($urandom);
      ctrl0 = v[2:0];
      gate[0] = v[3];
      {gate[1], ctrl1} = 4'($urandom);
      n = 1 + $urandom_range(7);
      cyc(3);
      {b0, b1, f0, f1} = {count0, count1, falls[0], falls[1]};
      en = 2'b11;
      cyc(dtc_pkg::PRESCALE * n - 4);
      en = 2'b00;
      cyc(4);
      chk("count0 step", count0 - b0, step(ctrl0, gate[0], n, falls[0] - f0));
      chk("count1 step", count1 - b1, step(ctrl1, gate[1], n, falls[1] - f1));
      $display("test %0d done", t);
    end
    wrap_up();
  end
  initial begin
    cyc(10000);
    err_count++;
    wrap_up();
  end
endmodule : dual_timer_count_source_tb_top

/* inc/dtc_pkg.sv */
// Purpose: shared constants and carriers for the dual timer count source
// Assumes: one clock domain, control bits come from logic on that clock
// Notes: count pins and gate pins are asynchronous and are synchronised in the top
package dtc_pkg;

  // count width and the internal divide ratio
  localparam int CNT_W = 16;
  localparam int PRESCALE = 12;
  localparam int NUM_TMR = 2;

  // pin vector layout: count inputs low, gate inputs high
  localparam int PIN_N = 4;
  localparam int PIN_CNT0 = 0;
  localparam int PIN_CNT1 = 1;
  localparam int PIN_GATE0 = 2;
  localparam int PIN_GATE1 = 3;

  // reset values
  localparam logic [3:0] PIN_RST = 4'h0;
  localparam logic [1:0] WRAP_RST = 2'h0;

  // per-timer control bits
  typedef struct packed {
    logic src_sel;
    logic gate_opt;
    logic run;
  } dtc_ctrl_s;

  // per-timer events seen by the counting channel
  typedef struct packed {
    logic tick;
    logic fall;
    logic gate;
  } dtc_evt_s;

endpackage : dtc_pkg

/* verilog/dtc_chan.sv */
// Purpose: one 16-bit count channel with source select, run and gate qualification
// Assumes: tick, fall and gate are already synchronous to mclk
// Notes: wrap pulses in the same cycle that the count shows zero after rolling over
`timescale 1ns/1ps
module dtc_chan #(
  parameter int CNT_W = dtc_pkg::CNT_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // control and events
  input wire dtc_pkg::dtc_ctrl_s ctrl,
  input wire dtc_pkg::dtc_evt_s evt,
  // count state
  output logic [CNT_W-1:0] count_q,
  output logic wrap_q
);

  logic [CNT_W-1:0] count_d;
  logic wrap_d;
  logic allow;
  logic step;

  initial begin
    if (CNT_W < 2) begin
      $error("dtc_chan: CNT_W must be at least 2");
    end
  end

  always_comb begin
    allow = ctrl.run && (!ctrl.gate_opt || evt.gate);
    step = allow && (ctrl.src_sel ? evt.fall : evt.tick);
    count_d = count_q;
    wrap_d = 1'b0;
    if (step) begin
      count_d = CNT_W'(count_q + 1'b1);
      wrap_d = &count_q;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
      wrap_q <= 1'b0;
    end else begin
      count_q <= count_d;
      wrap_q <= wrap_d;
    end
  end

endmodule : dtc_chan

/* verilog/dtc_top.sv */
// Purpose: counting front end of two timer/counters
// Assumes: mclk at 125 MHz; control bits come from logic on mclk
// Notes: pins pass two flip-flops before any logic reads them
//
// What this block does
// - two independent timer/counters, zero and one, each with a 16-bit count
// - internal timing mode advances count once per 12 clock periods while running
// - external counting mode advances count on each falling edge of own count pin
// - count pins sampled once per clock; edges taken only from those samples
// - select bit 1 picks count pin, 0 picks internal timing
// - gating off: count only while run bit is set
// - gating on: count only while run bit set and gate pin high
`timescale 1ns/1ps
module dtc_top #(
  parameter int CNT_W = dtc_pkg::CNT_W,
  parameter int PRESCALE = dtc_pkg::PRESCALE
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // per-timer control bits
  input wire dtc_pkg::dtc_ctrl_s ctrl0,
  input wire dtc_pkg::dtc_ctrl_s ctrl1,
  // external pins
  input wire logic first_count_input,
  input wire logic second_count_input,
  input wire logic [1:0] count_gate_input,
  // count values and rollover pulses
  output logic [CNT_W-1:0] count0,
  output logic [CNT_W-1:0] count1,
  output logic [dtc_pkg::NUM_TMR-1:0] wrap
);

  localparam int DIV_W = $clog2(PRESCALE);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PRESCALE - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;
  localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);

  initial begin
    if (PRESCALE < 2) begin
      $error("dtc_top: PRESCALE must be at least 2");
    end
    if (CNT_W < 2) begin
      $error("dtc_top: CNT_W must be at least 2");
    end
  end

  // internal divider
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic tick;

  always_comb begin
    tick = (div_q == DIV_LAST);
    div_d = tick ? DIV_ZERO : DIV_W'(div_q + DIV_ONE);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_q <= DIV_ZERO;
    end else begin
      div_q <= div_d;
    end
  end

  // pin synchronisers and edge samples
  logic [dtc_pkg::PIN_N-1:0] pin_raw;
  logic [dtc_pkg::PIN_N-1:0] meta_q;
  logic [dtc_pkg::PIN_N-1:0] meta_d;
  logic [dtc_pkg::PIN_N-1:0] sync_q;
  logic [dtc_pkg::PIN_N-1:0] sync_d;
  logic [1:0] prev_q;
  logic [1:0] prev_d;
  logic [1:0] fall;

  always_comb begin
    pin_raw = '0;
    pin_raw[dtc_pkg::PIN_CNT0] = first_count_input;
    pin_raw[dtc_pkg::PIN_CNT1] = second_count_input;
    pin_raw[dtc_pkg::PIN_GATE0] = count_gate_input[0];
    pin_raw[dtc_pkg::PIN_GATE1] = count_gate_input[1];
    meta_d = pin_raw;
    sync_d = meta_q;
    prev_d[0] = sync_q[dtc_pkg::PIN_CNT0];
    prev_d[1] = sync_q[dtc_pkg::PIN_CNT1];
    fall[0] = prev_q[0] && !sync_q[dtc_pkg::PIN_CNT0];
    fall[1] = prev_q[1] && !sync_q[dtc_pkg::PIN_CNT1];
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= dtc_pkg::PIN_RST;
      sync_q <= dtc_pkg::PIN_RST;
      prev_q <= dtc_pkg::WRAP_RST;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // event bundles per timer
  dtc_pkg::dtc_evt_s evt0;
  dtc_pkg::dtc_evt_s evt1;

  always_comb begin
    evt0.tick = tick;
    evt0.fall = fall[0];
    evt0.gate = sync_q[dtc_pkg::PIN_GATE0];
    evt1.tick = tick;
    evt1.fall = fall[1];
    evt1.gate = sync_q[dtc_pkg::PIN_GATE1];
  end

  // the two channels
  dtc_chan #(
    .CNT_W(CNT_W)
  ) u_chan0 (
    .mclk(mclk),
    .rstn(rstn),
    .ctrl(ctrl0),
    .evt(evt0),
    .count_q(count0),
    .wrap_q(wrap[0])
  );

  dtc_chan #(
    .CNT_W(CNT_W)
  ) u_chan1 (
    .mclk(mclk),
    .rstn(rstn),
    .ctrl(ctrl1),
    .evt(evt1),
    .count_q(count1),
    .wrap_q(wrap[1])
  );

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  logic ok0;
  logic ok1;
  assign ok0 = ctrl0.run && (!ctrl0.gate_opt || sync_q[dtc_pkg::PIN_GATE0]);
  assign ok1 = ctrl1.run && (!ctrl1.gate_opt || sync_q[dtc_pkg::PIN_GATE1]);

  tick_spacing_a: assert property (tick |=> !tick ##(PRESCALE - 1) tick)
    else $error("divider tick spacing wrong");

  timer_step_a: assert property ((ok0 && !ctrl0.src_sel && tick) |=> count0 == CNT_W'($past(count0) + 1'b1))
    else $error("first timer did not advance on tick");

  timer_idle_a: assert property ((!ctrl0.src_sel && !tick) |=> count0 == $past(count0))
    else $error("first timer moved without tick");

  pin_sync_a: assert property ($past(rstn, 2) |->
    sync_q[dtc_pkg::PIN_CNT0] == $past(first_count_input, 2) &&
    sync_q[dtc_pkg::PIN_CNT1] == $past(second_count_input, 2) &&
    sync_q[dtc_pkg::PIN_GATE0] == $past(count_gate_input[0], 2) &&
    sync_q[dtc_pkg::PIN_GATE1] == $past(count_gate_input[1], 2))
    else $error("pin not two-stage sampled");

  edge_step_a: assert property ((ok1 && ctrl1.src_sel && $past(sync_q[dtc_pkg::PIN_CNT1]) &&
    !sync_q[dtc_pkg::PIN_CNT1]) |=> count1 == CNT_W'($past(count1) + 1'b1))
    else $error("counter1 missed a falling edge");

  edge_only_a: assert property ((ctrl1.src_sel && !fall[1]) |=> count1 == $past(count1))
    else $error("counter1 moved without edge");

  run_hold_a: assert property ((!ctrl0.run && !ctrl0.gate_opt) |=> count0 == $past(count0))
    else $error("first timer counted while stopped");

  gate_hold_a: assert property ((ctrl1.gate_opt && !sync_q[dtc_pkg::PIN_GATE1]) |=> count1 == $past(count1))
    else $error("second timer counted with gate low");

  one_step_a: assert property (fall[0] |=> !fall[0])
    else $error("one edge gave two detections");

  indep_cnt_a: assert property ((!ctrl1.run && ok0 && tick && !ctrl0.src_sel) |=>
    count1 == $past(count1) && count0 != $past(count0))
    else $error("timers not independent");

  timer_run_c: cover property (ok0 && !ctrl0.src_sel && tick ##12 tick);
  edge_count_c: cover property (ok1 && ctrl1.src_sel && fall[1]);
  gate_block_c: cover property (ctrl1.gate_opt && ctrl1.run && !sync_q[dtc_pkg::PIN_GATE1] && fall[1]);
  wrap_seen_c: cover property (wrap[0]);

endmodule : dtc_top
